// >>> bench/cpu_bus_granter.sv
`timescale 1ns/10ps
module cpu_bus_granter
(
    // Clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // Arbitration
    input wire [3:0] delay_in,
    input wire bus_req_in,
    output reg bus_grant_out
);
    reg [3:0] wait_reg;
    // The CPU finishes its own cycle before handing the bus over.
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wait_reg <= 4'h0;
            bus_grant_out <= 1'b0;
        end
        else if (!bus_req_in)
        begin
            wait_reg <= 4'h0;
            bus_grant_out <= 1'b0;
        end
        else if (wait_reg == delay_in)
            bus_grant_out <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end
endmodule // cpu_bus_granter

// >>> bench/shared_dram_dual_access_sva.sv
`timescale 1ns/10ps
module shared_dram_dual_access_sva
(
    // Clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // Watched ports
    input wire loc_req_in,
    input wire loc_ack_out,
    input wire bus_req_out,
    input wire bus_grant_in,
    input wire vme_strobe_in,
    input wire vme_we_in,
    input wire vme_dtack_out,
    input wire vme_berr_out,
    input wire refresh_active_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_ack_one_cycle: assert property (loc_ack_out |=> !loc_ack_out)
        else $error("local ack wider than one cycle");
    a_ack_after_cycle: assert property (loc_ack_out |-> $past(loc_req_in, 20))
        else $error("local ack without a full memory cycle");
    a_req_from_strobe: assert property ($rose(bus_req_out) |-> $past(vme_strobe_in))
        else $error("bus request without a slave access");
    a_answer_after_grant: assert property ($rose(vme_dtack_out || vme_berr_out) |-> $past(bus_grant_in, 20))
        else $error("slave answer without granted memory cycle");
    a_bus_handed_back: assert property ($fell(bus_req_out) |-> vme_dtack_out || vme_berr_out)
        else $error("local bus released without an answer");
    a_answer_holds: assert property (vme_dtack_out && vme_strobe_in |=> vme_dtack_out)
        else $error("acknowledge dropped while strobe high");
    a_idle_no_answer: assert property (!vme_strobe_in && !$past(vme_strobe_in) |-> !vme_dtack_out && !vme_berr_out)
        else $error("slave answer without strobe");
    a_refresh_length: assert property ($rose(refresh_active_out) |-> ##24 refresh_active_out ##1 !refresh_active_out)
        else $error("refresh length wrong");
    a_no_ack_refresh: assert property (refresh_active_out |-> !loc_ack_out)
        else $error("access completed during refresh");
    a_berr_reads_only: assert property ($rose(vme_berr_out) |-> !vme_we_in)
        else $error("bus error on a write");
endmodule // shared_dram_dual_access_sva

// >>> bench/test_shared_dram_dual_access.sv
`timescale 1ns/10ps
module test_shared_dram_dual_access;
    reg sys_clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg size_4m_in = 1'b1;
    reg loc_req_in = 1'b0, loc_dma_in = 1'b0, loc_we_in = 1'b0, vme_strobe_in = 1'b0, vme_we_in = 1'b0;
    reg [3:0] loc_be_in = 4'hF, vme_be_in = 4'hF, delay = 4'h0;
    reg [5:0] vme_am_in = 6'h00;
    reg [31:0] loc_addr_in = 32'h0, loc_wdata_in = 32'h0, vme_addr_in = 32'h0, vme_wdata_in = 32'h0;
    wire loc_ack_out, bus_req_out, bus_grant_in, vme_dtack_out, vme_berr_out, parity_irq_out, refresh_active_out;
    wire [31:0] loc_rdata_out, vme_rdata_out, parity_addr_out;
    integer error_cnt = 0, comparisons = 0, lat, i;
    reg [31:0] q;
    reg got, bad, irq_seen;
    shared_dram_dual_access i_shared_dram_dual_access (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .size_4m_in(size_4m_in), .win_start_page_in(20'h00010), .win_end_page_in(20'h00011),
        .am_read_ok_in(64'h0000_0000_0000_2200), .am_write_ok_in(64'h0000_0000_0000_2000),
        .loc_req_in(loc_req_in), .loc_dma_in(loc_dma_in), .loc_we_in(loc_we_in), .loc_be_in(loc_be_in),
        .loc_addr_in(loc_addr_in), .loc_wdata_in(loc_wdata_in), .loc_ack_out(loc_ack_out),
        .loc_rdata_out(loc_rdata_out), .bus_req_out(bus_req_out), .bus_grant_in(bus_grant_in),
        .vme_strobe_in(vme_strobe_in), .vme_we_in(vme_we_in), .vme_am_in(vme_am_in), .vme_be_in(vme_be_in),
        .vme_addr_in(vme_addr_in), .vme_wdata_in(vme_wdata_in), .vme_dtack_out(vme_dtack_out),
        .vme_berr_out(vme_berr_out), .vme_rdata_out(vme_rdata_out), .parity_irq_out(parity_irq_out),
        .parity_addr_out(parity_addr_out), .refresh_active_out(refresh_active_out));
    cpu_bus_granter i_cpu_bus_granter (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .delay_in(delay),
        .bus_req_in(bus_req_out), .bus_grant_out(bus_grant_in));
    always #5 sys_clk_in = ~sys_clk_in;
    task check(input [31:0] seen, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
            begin error_cnt = error_cnt + 1; $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp); end
    end
    endtask
    task loc_op(input we, input [31:0] a, input [31:0] d);
    begin
        @(negedge sys_clk_in) {loc_we_in, loc_addr_in, loc_wdata_in, loc_req_in} = {we, a, d, 1'b1};
        lat = 0;
        while (loc_ack_out !== 1'b1 && lat < 100) begin @(posedge sys_clk_in); #1 lat = lat + 1; end
        q = loc_rdata_out;
        got = loc_ack_out;
        irq_seen = parity_irq_out;
        @(negedge sys_clk_in) loc_req_in = 1'b0;
    end
    endtask
    task vme_op(input we, input [5:0] am, input [31:0] a, input [31:0] d);
    begin
        @(negedge sys_clk_in) {vme_we_in, vme_am_in, vme_addr_in, vme_wdata_in, vme_strobe_in} = {we, am, a, d, 1'b1};
        lat = 0;
        while (vme_dtack_out !== 1'b1 && vme_berr_out !== 1'b1 && lat < 80) begin @(posedge sys_clk_in); #1 lat = lat + 1; end
        q = vme_rdata_out;
        got = vme_dtack_out;
        bad = vme_berr_out;
        @(negedge sys_clk_in) vme_strobe_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
    end
    endtask
    task t_local;
    begin
        loc_op(1'b1, 32'h200, 32'h5A5A_C33C);
        check(lat, 21);
        loc_be_in = 4'h1;
        loc_op(1'b1, 32'h200, 32'h0000_00FF);
        loc_be_in = 4'hF;
        loc_dma_in = 1'b1;
        loc_op(1'b0, 32'h200, 32'h0);
        loc_dma_in = 1'b0;
        check(q, 32'h5A5A_C3FF);
        check(irq_seen, 0);
        size_4m_in = 1'b0;
        loc_op(1'b0, 32'h0010_0200, 32'h0);
        check(got, 0);
        size_4m_in = 1'b1;
        loc_op(1'b0, 32'h0010_0200, 32'h0);
        check(got, 1);
        check(q, 32'h5A5A_C3FF);
    end
    endtask
    task t_vme;
    begin
        delay = 4'h9;
        vme_op(1'b1, 6'h0D, 32'h0001_0300, 32'h1234_5678);
        check(got, 1);
        delay = 4'h0;
        loc_op(1'b0, 32'h300, 32'h0);
        check(q, 32'h1234_5678);
        vme_op(1'b0, 6'h09, 32'h0001_0300, 32'h0);
        check(q, 32'h1234_5678);
    end
    endtask
    task t_refused;
    begin
        vme_op(1'b1, 6'h09, 32'h0001_0300, 32'hDEAD_0000);
        check(got, 0);
        vme_op(1'b0, 6'h0D, 32'h0001_0300, 32'h0);
        check(q, 32'h1234_5678);
        vme_op(1'b0, 6'h0D, 32'h0001_2000, 32'h0);
        check({got, bad}, 2'b00);
        vme_op(1'b0, 6'h0D, 32'h0000_FFFC, 32'h0);
        check({got, bad}, 2'b00);
        vme_op(1'b0, 6'h3F, 32'h0001_0300, 32'h0);
        check({got, bad}, 2'b00);
    end
    endtask
    task t_parity;
    begin
        i_shared_dram_dual_access.i_parity_word_mem.mem[10'h0C0] =
            {i_shared_dram_dual_access.i_parity_word_mem.mem[10'h0C0][35:9], 9'h000};
        loc_op(1'b0, 32'h300, 32'h0);
        check({got, irq_seen}, 2'b11);
        check(parity_addr_out, 32'h0000_0300);
        vme_op(1'b0, 6'h0D, 32'h0001_0300, 32'h0);
        check({got, bad}, 2'b01);
        check(parity_addr_out, 32'h0001_0300);
    end
    endtask
    task t_refresh;
    begin
        for (i = 0; i < 3000 && refresh_active_out !== 1'b1; i = i + 1) begin @(posedge sys_clk_in); #1; end
        for (i = 0; i < 3000 && refresh_active_out === 1'b1; i = i + 1) begin @(posedge sys_clk_in); #1; end
        for (i = 0; i < 3000 && refresh_active_out !== 1'b1; i = i + 1) begin @(posedge sys_clk_in); #1; end
        check(i + 25, 1500);
        loc_op(1'b0, 32'h300, 32'h0);
        check(lat, 46);
    end
    endtask
    task complete_run;
    begin
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        #400000 error_cnt = error_cnt + 1;
        complete_run;
    end
    initial
    begin
        repeat (2) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        t_local;
        t_vme;
        t_refused;
        t_parity;
        t_refresh;
        complete_run;
    end
endmodule // test_shared_dram_dual_access
bind shared_dram_dual_access shared_dram_dual_access_sva i_shared_dram_dual_access_sva (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .loc_req_in(loc_req_in), .loc_ack_out(loc_ack_out), .bus_req_out(bus_req_out),
    .bus_grant_in(bus_grant_in), .vme_strobe_in(vme_strobe_in), .vme_we_in(vme_we_in),
    .vme_dtack_out(vme_dtack_out), .vme_berr_out(vme_berr_out), .refresh_active_out(refresh_active_out));

// >>> pkg/dram_consts.vh
`ifndef DRAM_CONSTS_VH
`define DRAM_CONSTS_VH
// Timing at 100 MHz system clock.
`define CLK_PERIOD_NS 10
`define MEM_CYCLE_NS 200
`define MEM_CYCLE_CLKS (`MEM_CYCLE_NS / `CLK_PERIOD_NS)
`define LOCAL_CLK_NS 50
`define REFRESH_US 15
`define REFRESH_CLKS ((`REFRESH_US * 1000) / `CLK_PERIOD_NS)
`define REFRESH_MAX_DELAY_LCLK 5
`define REFRESH_LEN_CLKS ((`REFRESH_MAX_DELAY_LCLK * `LOCAL_CLK_NS) / `CLK_PERIOD_NS)
// Window granularity: 4 Kbyte pages, address bits 31:12.
`define PAGE_LSB 12
`define PAGE_W 20
// Memory sizes: 1 Mbyte or 4 Mbyte, word addressed.
`define MEM_AW 20
`define SIZE_1M_TOP_PAGE 20'h000FF
`define SIZE_4M_TOP_PAGE 20'h003FF
`endif

// >>> rtl/parity_word_mem.v
`timescale 1ns/10ps
// Word-wide storage with one parity bit per byte held beside the data.
module parity_word_mem
(
    // Clock
    input wire sys_clk_in,
    // Access
    input wire en_in,
    input wire we_in,
    input wire [3:0] be_in,
    input wire [9:0] addr_in,
    input wire [35:0] wdata_in,
    // Read data
    output reg [35:0] rdata_out
);
    reg [35:0] mem [0:1023];
    integer b;
    // One process owns the array so each byte lane write has a single driver.
    always @(posedge sys_clk_in)
    begin
        for (b = 0; b < 4; b = b + 1)
        begin
            if (en_in && we_in && be_in[b])
            begin
                mem[addr_in][b*9 +: 9] <= wdata_in[b*9 +: 9];
            end
        end
        if (en_in)
        begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule // parity_word_mem

// >>> rtl/shared_dram_dual_access.v
`timescale 1ns/10ps
`include "dram_consts.vh"
// Functional notes
// - Two capacity options; decode accesses by size.
// - Each DRAM access takes one 200 ns cycle.
// - Refresh issued automatically every 15 microseconds.
// - Pending refresh delays access at most five local clocks (25 system clocks).
// - CPU programs VME window and modifier codes.
// - Window start and end in 4 Kbyte steps.
// - Writes blockable per address modifier code.
// - VME access requests local bus, awaits grant.
// - Read data latched; write ends after storing.
// - Release local bus, finish VME handshake later.
// - Parity generated on write, checked on read.
// - VME read parity error ends with BERR.
// - Local parity error raises local interrupt.
// - Failing address captured in readable register.
module shared_dram_dual_access
(
    // Clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // Configuration from the local CPU
    input wire size_4m_in,
    input wire [19:0] win_start_page_in,
    input wire [19:0] win_end_page_in,
    input wire [63:0] am_read_ok_in,
    input wire [63:0] am_write_ok_in,
    // Local access (CPU or DMA)
    input wire loc_req_in,
    input wire loc_dma_in,
    input wire loc_we_in,
    input wire [3:0] loc_be_in,
    input wire [31:0] loc_addr_in,
    input wire [31:0] loc_wdata_in,
    output wire loc_ack_out,
    output reg [31:0] loc_rdata_out,
    // Local bus arbitration with the CPU
    output reg bus_req_out,
    input wire bus_grant_in,
    // VMEbus slave side
    input wire vme_strobe_in,
    input wire vme_we_in,
    input wire [5:0] vme_am_in,
    input wire [3:0] vme_be_in,
    input wire [31:0] vme_addr_in,
    input wire [31:0] vme_wdata_in,
    output reg vme_dtack_out,
    output reg vme_berr_out,
    output reg [31:0] vme_rdata_out,
    // Status
    output reg parity_irq_out,
    output reg [31:0] parity_addr_out,
    output reg refresh_active_out
);
    localparam S_IDLE = 5'b00001;
    localparam S_REFRESH = 5'b00010;
    localparam S_LOCAL = 5'b00100;
    localparam S_VREQ = 5'b01000;
    localparam S_VMEM = 5'b10000;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [10:0] ref_cnt_reg;
    reg ref_pend_reg;
    reg [4:0] cyc_cnt_reg;
    reg cur_we_reg;
    reg [3:0] cur_be_reg;
    reg [31:0] cur_addr_reg;
    reg [35:0] cur_wdata_reg;
    reg loc_ack_reg;
    wire [35:0] mem_rdata;

    // Returns data with an odd-parity bit appended to every byte.
    function [35:0] add_parity;
        input [31:0] d;
        integer i;
        begin
            add_parity = 36'h0;
            for (i = 0; i < 4; i = i + 1)
            begin
                add_parity[i*9 +: 9] = {~^d[i*8 +: 8], d[i*8 +: 8]};
            end
        end
    endfunction

    // Flags a byte lane whose stored parity does not match.
    function parity_bad;
        input [35:0] w;
        input [3:0] be;
        integer i;
        begin
            parity_bad = 1'b0;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (be[i] && (^w[i*9 +: 9] == 1'b0))
                begin
                    parity_bad = 1'b1;
                end
            end
        end
    endfunction

    // True when a page lies inside installed memory.
    function in_memory;
        input [19:0] page;
        input big;
        begin
            in_memory = big ? (page <= `SIZE_4M_TOP_PAGE) : (page <= `SIZE_1M_TOP_PAGE);
        end
    endfunction

    wire [19:0] vme_page = vme_addr_in[31:`PAGE_LSB];
    wire [19:0] vme_off_page = vme_page - win_start_page_in;
    wire vme_in_win = (vme_page >= win_start_page_in) && (vme_page <= win_end_page_in) &&
        in_memory(vme_off_page, size_4m_in);
    wire vme_am_ok = vme_we_in ? am_write_ok_in[vme_am_in] : am_read_ok_in[vme_am_in];
    wire vme_hit = vme_strobe_in && vme_in_win && vme_am_ok && !vme_dtack_out && !vme_berr_out;
    wire loc_hit = loc_req_in && in_memory(loc_addr_in[31:`PAGE_LSB], size_4m_in) && !loc_ack_reg;
    wire cycle_end = (cyc_cnt_reg == (`MEM_CYCLE_CLKS - 1));
    wire read_bad = !cur_we_reg && parity_bad(mem_rdata, cur_be_reg);
    wire mem_en = (state_reg == S_LOCAL || state_reg == S_VMEM) && (cyc_cnt_reg == 5'h00);
    assign loc_ack_out = loc_ack_reg;

    parity_word_mem i_parity_word_mem
    (
        .sys_clk_in(sys_clk_in),
        .en_in(mem_en),
        .we_in(cur_we_reg),
        .be_in(cur_be_reg),
        .addr_in(cur_addr_reg[11:2]),
        .wdata_in(cur_wdata_reg),
        .rdata_out(mem_rdata)
    );

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (ref_pend_reg)
                    state_next = S_REFRESH;
                else if (vme_hit)
                    state_next = S_VREQ;
                else if (loc_hit)
                    state_next = S_LOCAL;
            end
            S_REFRESH:
            begin
                if (cyc_cnt_reg == (`REFRESH_LEN_CLKS - 1))
                    state_next = S_IDLE;
            end
            S_LOCAL:
            begin
                if (cycle_end)
                    state_next = S_IDLE;
            end
            S_VREQ:
            begin
                if (bus_grant_in)
                    state_next = S_VMEM;
            end
            S_VMEM:
            begin
                if (cycle_end)
                    state_next = S_IDLE;
            end
            default:
            begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= S_IDLE;
            ref_cnt_reg <= 11'h000;
            ref_pend_reg <= 1'b0;
            cyc_cnt_reg <= 5'h00;
            cur_we_reg <= 1'b0;
            cur_be_reg <= 4'h0;
            cur_addr_reg <= 32'h00000000;
            cur_wdata_reg <= 36'h000000000;
            loc_ack_reg <= 1'b0;
            loc_rdata_out <= 32'h00000000;
            bus_req_out <= 1'b0;
            vme_dtack_out <= 1'b0;
            vme_berr_out <= 1'b0;
            vme_rdata_out <= 32'h00000000;
            parity_irq_out <= 1'b0;
            parity_addr_out <= 32'h00000000;
            refresh_active_out <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            loc_ack_reg <= 1'b0;
            parity_irq_out <= 1'b0;
            if (ref_cnt_reg == (`REFRESH_CLKS - 1))
            begin
                ref_cnt_reg <= 11'h000;
                ref_pend_reg <= 1'b1;
            end
            else
            begin
                ref_cnt_reg <= ref_cnt_reg + 11'h001;
                if (state_reg == S_REFRESH)
                    ref_pend_reg <= 1'b0;
            end
            refresh_active_out <= (state_next == S_REFRESH);
            if (state_next != state_reg)
                cyc_cnt_reg <= 5'h00;
            else if (state_reg == S_REFRESH || state_reg == S_LOCAL || state_reg == S_VMEM)
                cyc_cnt_reg <= cyc_cnt_reg + 5'h01;
            if (state_reg == S_IDLE && state_next == S_VREQ)
            begin
                cur_we_reg <= vme_we_in;
                cur_be_reg <= vme_be_in;
                cur_addr_reg <= {vme_off_page, vme_addr_in[`PAGE_LSB-1:0]};
                cur_wdata_reg <= add_parity(vme_wdata_in);
                bus_req_out <= 1'b1;
            end
            if (state_reg == S_IDLE && state_next == S_LOCAL)
            begin
                cur_we_reg <= loc_we_in;
                cur_be_reg <= loc_be_in;
                cur_addr_reg <= loc_addr_in;
                cur_wdata_reg <= add_parity(loc_wdata_in);
            end
            if (state_reg == S_LOCAL && cycle_end)
            begin
                loc_ack_reg <= 1'b1;
                loc_rdata_out <= {mem_rdata[34:27], mem_rdata[25:18], mem_rdata[16:9], mem_rdata[7:0]};
                if (read_bad)
                begin
                    parity_irq_out <= 1'b1;
                    parity_addr_out <= cur_addr_reg;
                end
            end
            // The slave answer is retired on its own while the local bus is already back with the CPU.
            if (!vme_strobe_in)
            begin
                vme_dtack_out <= 1'b0;
                vme_berr_out <= 1'b0;
            end
            if (state_reg == S_VMEM && cycle_end)
            begin
                bus_req_out <= 1'b0;
                vme_rdata_out <= {mem_rdata[34:27], mem_rdata[25:18], mem_rdata[16:9], mem_rdata[7:0]};
                if (read_bad)
                begin
                    vme_berr_out <= 1'b1;
                    parity_addr_out <= {cur_addr_reg[31:`PAGE_LSB] + win_start_page_in,
                        cur_addr_reg[`PAGE_LSB-1:0]};
                end
                else
                    vme_dtack_out <= 1'b1;
            end
        end
    end
endmodule // shared_dram_dual_access
